//--- mac_model.sv
// mac client model: loops accepted transmit beats back to the receive side
// assumes one clock; stall and fault choice come from the bench
module mac_model
    import pkt_client_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  pkt_client_pkg::beat_s tx_beat,
    input  wire logic             tx_valid,
    output logic                  tx_ready,
    output pkt_client_pkg::beat_s rx_beat,
    output logic                  rx_valid,
    input  wire logic             stall,
    input  wire logic [1:0]       bad_kind,
    input  wire logic [7:0]       bad_frame
);
    logic [7:0] nfr_q;
    logic       hit;
    beat_s      fb;
    assign tx_ready = !stall;
    assign hit      = nfr_q == bad_frame;
    always_comb begin
        fb = tx_beat;
        if (hit && bad_kind == 2'h1 && tx_beat.sop) fb.data[0] = !tx_beat.data[0];
        if (hit && bad_kind == 2'h3 && tx_beat.sop) fb.data[32] = !tx_beat.data[32];
        if (hit && bad_kind == 2'h2 && tx_beat.eop) fb.error = 1'b1;
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx_beat  <= '0;
            nfr_q    <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            rx_valid <= 1'b1;
            rx_beat  <= fb;
            if (tx_beat.eop) nfr_q <= nfr_q + 8'h01;
        end else begin
            rx_valid <= 1'b0;
            rx_beat  <= ~rx_beat;
        end
    end
endmodule

//--- pkt_client.sv
// packet client top: generator, monitor, tx fifo and host register slave
// assumes a 32-bit host master with waitrequest and a 256-bit mac client
module pkt_client
    import pkt_client_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [ADDR_W+1:0]     address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [3:0]            byteenable,
    input  wire logic [31:0]           writedata,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    output pkt_client_pkg::beat_s      tx_beat,
    output logic                       tx_valid,
    input  wire logic                  tx_ready,
    input  pkt_client_pkg::beat_s      rx_beat,
    input  wire logic                  rx_valid,
    output logic                       rx_ready
);
    typedef enum logic [1:0] {G_IDLE, G_HEAD, G_BODY} gen_e;

    gen_e             st_q, st_d;
    logic [31:0]      ctrl_q, ctrl_d, burst_q, burst_d, pay_q, pay_d, seq0_q, seq0_d;
    logic [LEN_W-1:0] len_q, len_d, flen_q, flen_d, left_q, left_d;
    logic [31:0]      seq_q, seq_d, sent_q, sent_d, txc_q, txc_d;
    logic [15:0]      lfsr_q, lfsr_d;
    logic [7:0]       inc_q, inc_d;
    logic             run_q, run_d, done_q, done_d, ack_q, ack_d;
    logic [31:0]      rd_q, rd_d;
    beat_s            gb;
    logic             gvalid, gready, fire;
    logic             start_p, stop_p, clr_p, wr_ok;
    logic [31:0]      wmask;
    logic [31:0]      rx_cnt, err_int, err_seq, err_len;
    logic [LEN_W-1:0] rlen;
    logic [ADDR_W-1:0] widx;

    // bus slave answers one cycle after request, waitrequest low then
    assign waitrequest = (read || write) && !ack_q;
    assign wr_ok       = write && ack_q;
    assign widx        = address[ADDR_W+1:2];
    assign wmask       = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign start_p     = wr_ok && widx == REG_CTRL && byteenable[0] && writedata[CTRL_START];
    assign stop_p      = wr_ok && widx == REG_CTRL && byteenable[0] && writedata[CTRL_STOP];
    assign clr_p       = wr_ok && widx == REG_CTRL && byteenable[0] && writedata[CTRL_CLR];
    assign readdata    = rd_q;

    always_comb begin
        ctrl_d = ctrl_q;
        len_d  = len_q;
        burst_d = burst_q;
        pay_d  = pay_q;
        seq0_d = seq0_q;
        ack_d  = (read || write) && !ack_q;
        rd_d   = rd_q;
        if (wr_ok) begin
            if (widx == REG_CTRL) begin
                ctrl_d = (writedata & wmask & 32'h0000_001c) | (ctrl_q & ~(wmask & 32'h0000_001c));
            end else if (widx == REG_LEN) begin
                // clamp into the legal fixed length range
                if ((writedata[LEN_W:0] & wmask[LEN_W:0]) < {1'b0, LEN_MIN}) begin
                    len_d = LEN_MIN;
                end else if ((writedata[LEN_W:0] & wmask[LEN_W:0]) > {1'b0, LEN_MAX}) begin
                    len_d = LEN_MAX;
                end else begin
                    len_d = LEN_W'(writedata[LEN_W:0] & wmask[LEN_W:0]);
                end
            end else if (widx == REG_BURST) begin
                burst_d = (writedata & wmask) | (burst_q & ~wmask);
            end else if (widx == REG_PAYLOAD) begin
                pay_d = (writedata & wmask) | (pay_q & ~wmask);
            end else if (widx == REG_SEQ0) begin
                seq0_d = (writedata & wmask) | (seq0_q & ~wmask);
            end
        end
        if (read && !ack_q) begin
            if (widx == REG_CTRL) begin
                rd_d = ctrl_q;
            end else if (widx == REG_LEN) begin
                rd_d = {16'h0000, len_q};
            end else if (widx == REG_BURST) begin
                rd_d = burst_q;
            end else if (widx == REG_PAYLOAD) begin
                rd_d = pay_q;
            end else if (widx == REG_SEQ0) begin
                rd_d = seq0_q;
            end else if (widx == REG_STATUS) begin
                rd_d = {30'h0, done_q, run_q};
            end else if (widx == REG_TX_CNT) begin
                rd_d = txc_q;
            end else if (widx == REG_RX_CNT) begin
                rd_d = rx_cnt;
            end else if (widx == REG_ERR_INT) begin
                rd_d = err_int;
            end else if (widx == REG_ERR_SEQ) begin
                rd_d = err_seq;
            end else if (widx == REG_ERR_LEN) begin
                rd_d = err_len;
            end else begin
                rd_d = 32'h0000_0000;
            end
        end
    end

    // random length from lfsr, folded into 64..1087 bytes
    assign rlen = LEN_W'(RAND_MIN + {6'h00, lfsr_q[9:0]});
    assign fire = gvalid && gready;

    always_comb begin
        st_d   = st_q;
        run_d  = run_q;
        done_d = done_q;
        seq_d  = seq_q;
        sent_d = sent_q;
        txc_d  = clr_p ? 32'h0 : txc_q;
        flen_d = flen_q;
        left_d = left_q;
        inc_d  = inc_q;
        lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        gvalid = 1'b0;
        gb     = '0;
        if (start_p) begin
            run_d  = 1'b1;
            done_d = 1'b0;
            sent_d = '0;
            seq_d  = seq0_q;
        end
        if (stop_p) begin
            run_d = 1'b0;
        end
        case (st_q)
            G_IDLE: begin
                if (run_q && !stop_p) begin
                    flen_d = ctrl_q[CTRL_RANDOM] ? rlen : len_q;
                    st_d   = G_HEAD;
                end
            end
            G_HEAD, G_BODY: begin
                gvalid = 1'b1;
                gb.sop = (st_q == G_HEAD);
                for (int i = 0; i < DATA_W / 8; i++) begin
                    // payload pattern: incrementing bytes or fixed word
                    gb.data[i*8 +: 8] = ctrl_q[CTRL_FIXPL] ? pay_q[(i%4)*8 +: 8] : 8'(inc_q + 8'(i));
                end
                if (st_q == G_HEAD) begin
                    gb.data[47:0] = {flen_q, seq_q};
                end
                gb.eop   = (st_q == G_HEAD ? flen_q : left_q) <= LEN_W'(32);
                gb.empty = gb.eop ? EMPTY_W'(6'd32 - 6'((st_q == G_HEAD ? flen_q : left_q))) : '0;
                if (fire) begin
                    inc_d  = 8'(inc_q + 8'd32);
                    left_d = LEN_W'((st_q == G_HEAD ? flen_q : left_q) - LEN_W'(32));
                    st_d   = G_BODY;
                    if (gb.eop) begin
                        st_d   = G_IDLE;
                        seq_d  = seq_q + 32'd1;
                        txc_d  = txc_d + 32'd1;
                        sent_d = sent_q + 32'd1;
                        // burst stops at the count, continuous keeps going
                        if (ctrl_q[CTRL_BURST] && sent_q + 32'd1 >= burst_q) begin
                            run_d  = 1'b0;
                            done_d = 1'b1;
                        end
                    end
                end
            end
            default: st_d = G_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q  <= '0;
            len_q   <= LEN_RESET;
            burst_q <= BURST_RESET;
            pay_q   <= PAYLOAD_RESET;
            seq0_q  <= '0;
            ack_q   <= 1'b0;
            rd_q    <= '0;
            st_q    <= G_IDLE;
            run_q   <= 1'b0;
            done_q  <= 1'b0;
            seq_q   <= '0;
            sent_q  <= '0;
            txc_q   <= '0;
            flen_q  <= LEN_RESET;
            left_q  <= '0;
            inc_q   <= '0;
            lfsr_q  <= LFSR_SEED;
        end else begin
            ctrl_q  <= ctrl_d;
            len_q   <= len_d;
            burst_q <= burst_d;
            pay_q   <= pay_d;
            seq0_q  <= seq0_d;
            ack_q   <= ack_d;
            rd_q    <= rd_d;
            st_q    <= st_d;
            run_q   <= run_d;
            done_q  <= done_d;
            seq_q   <= seq_d;
            sent_q  <= sent_d;
            txc_q   <= txc_d;
            flen_q  <= flen_d;
            left_q  <= left_d;
            inc_q   <= inc_d;
            lfsr_q  <= lfsr_d;
        end
    end

    // 256-bit transmit stream through the fifo
    pkt_fifo #(
        .WIDTH (BEAT_W),
        .DEPTH (8)
    ) u_tx_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   (gb),
        .in_valid  (gvalid),
        .in_ready  (gready),
        .out_data  (tx_beat),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // 256-bit receive stream into the monitor
    pkt_mon u_mon (
        .clk       (clk),
        .rstn      (rstn),
        .rx_beat   (rx_beat),
        .rx_valid  (rx_valid),
        .rx_ready  (rx_ready),
        .clr       (clr_p),
        .seq_first (seq0_q),
        .rx_cnt    (rx_cnt),
        .err_int   (err_int),
        .err_seq   (err_seq),
        .err_len   (err_len)
    );

    // register and bus checks
    a_len_in_range: assert property (@(posedge clk) disable iff (!rstn)
        len_q >= LEN_MIN && len_q <= LEN_MAX) else $error("fixed length out of range");

    a_bus_one_wait: assert property (@(posedge clk) disable iff (!rstn)
        (read && !ack_q) |=> !waitrequest || !read) else $error("slave answer late");

    a_status_read: assert property (@(posedge clk) disable iff (!rstn)
        (read && !ack_q && widx == REG_STATUS) |=> readdata == {30'h0, $past(done_q), $past(run_q)})
        else $error("status read wrong");

    // generator mode checks
    a_burst_stops: assert property (@(posedge clk) disable iff (!rstn)
        (fire && gb.eop && ctrl_q[CTRL_BURST] && sent_q + 32'd1 >= burst_q && !start_p)
        |=> !run_q && done_q) else $error("burst did not stop");

    a_tx_count: assert property (@(posedge clk) disable iff (!rstn)
        (fire && gb.eop && !clr_p) |=> txc_q == $past(txc_q) + 32'd1)
        else $error("sent frame not counted");

    a_cont_runs: assert property (@(posedge clk) disable iff (!rstn)
        (fire && gb.eop && !ctrl_q[CTRL_BURST] && run_q && !stop_p) |=> run_q) else $error("continuous stopped");

    a_stop_halts: assert property (@(posedge clk) disable iff (!rstn)
        stop_p |=> !run_q)
        else $error("stop ignored");

    a_frame_gap: assert property (@(posedge clk) disable iff (!rstn)
        (fire && gb.eop) |=> !gvalid)
        else $error("no idle cycle after frame");

    // payload and length checks
    a_head_seq: assert property (@(posedge clk) disable iff (!rstn)
        (gvalid && gb.sop) |-> gb.data[31:0] == seq_q) else $error("header sequence wrong");

    a_fixed_payload: assert property (@(posedge clk) disable iff (!rstn)
        (gvalid && !gb.sop && ctrl_q[CTRL_FIXPL]) |-> gb.data[31:0] == pay_q) else $error("payload not fixed");

    a_inc_step: assert property (@(posedge clk) disable iff (!rstn)
        (gvalid && !gb.sop && !ctrl_q[CTRL_FIXPL]) |-> gb.data[15:8] == 8'(gb.data[7:0] + 8'd1))
        else $error("payload not incrementing");

    a_random_len: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == G_IDLE && run_q && !stop_p && ctrl_q[CTRL_RANDOM]) |=> flen_q >= RAND_MIN)
        else $error("random length too small");

    a_random_max: assert property (@(posedge clk) disable iff (!rstn)
        (st_q == G_IDLE && run_q && !stop_p && ctrl_q[CTRL_RANDOM]) |=> flen_q < RAND_MIN + 16'd1024)
        else $error("random length too large");

    // stream checks
    a_stall_holds: assert property (@(posedge clk) disable iff (!rstn)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_beat)) else $error("tx beat dropped");

    a_body_full: assert property (@(posedge clk) disable iff (!rstn)
        (tx_valid && !tx_beat.eop) |-> tx_beat.empty == EMPTY_W'(0))
        else $error("empty set on inner beat");

    c_burst_done: cover property (@(posedge clk) disable iff (!rstn) $rose(done_q));
    c_tx_stall: cover property (@(posedge clk) disable iff (!rstn) !gready && gvalid);
    c_multi_beat: cover property (@(posedge clk) disable iff (!rstn) fire && !gb.sop && gb.eop);
    c_cont_stop: cover property (@(posedge clk) disable iff (!rstn) stop_p && run_q && !ctrl_q[CTRL_BURST]);
endmodule

//--- pkt_client_pkg.sv
// package for the packet client: register map, field layouts, carriers
// assumes a 32-bit memory-mapped host and a 256-bit streaming mac client
// Notes on behaviour
// - fixed frame length programmable from 33 up to 32768 bytes
// - fixed generator runs continuous or sends a limited burst
// - payload is an incrementing pattern or a programmable fixed word
// - monitor checks sequence number and length against expected, flags mismatches
// - frames move to and from the mac on 256-bit streams, one each way
// - configuration and status reached over a 32-bit memory-mapped slave
// - generator can also produce frames of random length
// - monitor parses every received frame and checks its integrity
package pkt_client_pkg;
    localparam int DATA_W   = 256;
    localparam int EMPTY_W  = 5;
    localparam int ADDR_W   = 4;
    localparam int LEN_W    = 16;

    // word addresses on the host port
    localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_LEN      = 4'h1;
    localparam logic [ADDR_W-1:0] REG_BURST    = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PAYLOAD  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SEQ0     = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_TX_CNT   = 4'h6;
    localparam logic [ADDR_W-1:0] REG_RX_CNT   = 4'h7;
    localparam logic [ADDR_W-1:0] REG_ERR_INT  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_ERR_SEQ  = 4'h9;
    localparam logic [ADDR_W-1:0] REG_ERR_LEN  = 4'ha;

    // ctrl fields
    localparam int CTRL_START  = 0;
    localparam int CTRL_STOP   = 1;
    localparam int CTRL_BURST  = 2;
    localparam int CTRL_FIXPL  = 3;
    localparam int CTRL_RANDOM = 4;
    localparam int CTRL_CLR    = 5;

    localparam logic [LEN_W-1:0] LEN_MIN   = 16'd33;
    localparam logic [LEN_W-1:0] LEN_MAX   = 16'd32768;
    localparam logic [LEN_W-1:0] LEN_RESET = 16'd64;
    localparam logic [LEN_W-1:0] RAND_MIN  = 16'd64;
    localparam logic [15:0]      LFSR_SEED = 16'hace1;
    localparam logic [31:0]      PAYLOAD_RESET = 32'h0000_0000;
    localparam logic [31:0]      BURST_RESET   = 32'h0000_0010;

    typedef struct packed {
        logic [DATA_W-1:0]  data;
        logic               sop;
        logic               eop;
        logic [EMPTY_W-1:0] empty;
        logic               error;
    } beat_s;

    localparam int BEAT_W = $bits(beat_s);
endpackage

//--- pkt_client_tb.sv
// bench for the packet client: host bus driver, transmit frame watcher
// assumes the mac model loops transmit frames back to the monitor
module pkt_client_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pkt_client_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W+1:0] address = '0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [3:0]        byteenable = 4'hf;
    logic [31:0]       writedata = '0;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              tx_valid;
    logic              tx_ready;
    logic              rx_valid;
    logic              rx_ready;
    beat_s             tx_beat;
    beat_s             rx_beat;
    logic              stall = 1'b0;
    logic [1:0]        bad_kind = 2'h0;
    logic [7:0]        bad_frame = 8'hff;
    int                n_mismatch = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                nfr = 0;
    int                nby = 0;
    logic [32:0]       rq[$];
    logic [31:0]       exp_seq = '0;
    logic [31:0]       rd = '0;
    logic [15:0]       exp_len = '0;
    logic [15:0]       hdr = '0;
    logic              fix_pl = 1'b0;
    localparam logic [31:0] PAY = 32'h5a3c_96e1;

    pkt_client dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_beat(rx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready));
    mac_model mac (.clk(clk), .rstn(rstn), .tx_beat(tx_beat), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_beat(rx_beat), .rx_valid(rx_valid), .stall(stall),
        .bad_kind(bad_kind), .bad_frame(bad_frame));

    always #10 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        stall <= ($urandom % 4) == 0;
        if (cyc == 90000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // host bus transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
        if (!w) rq.push_back({c, d});
        address <= {a, 2'b00};
        read <= !w;
        write <= w;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, e, 1'b1);
    endtask

    always @(posedge clk) if (read && waitrequest === 1'b0) begin
        if (rq[0][32]) chk("readdata", rq[0][31:0], readdata);
        void'(rq.pop_front());
    end

    always @(posedge clk) if (tx_valid === 1'b1 && tx_ready) begin
        if (tx_beat.sop) begin
            chk("sequence", exp_seq, tx_beat.data[31:0]);
            hdr = tx_beat.data[47:32];
            if (exp_len != 0) chk("length field", {16'h0, exp_len}, {16'h0, hdr});
            nby = 0;
            exp_seq++;
        end else if (!tx_beat.eop && fix_pl) chk("fixed payload", PAY, tx_beat.data[31:0]);
        else if (!tx_beat.eop) chk("payload step", {24'h0, tx_beat.data[7:0] + 8'h01}, {24'h0, tx_beat.data[15:8]});
        nby = nby + 32 - int'(tx_beat.empty);
        if (tx_beat.eop) begin
            nfr++;
            chk("frame bytes", {16'h0, hdr}, 32'(nby));
            if (exp_len == 0) chk("random range", 32'h1, {31'h0, hdr >= RAND_MIN && hdr < RAND_MIN + 16'd1024});
        end
    end

    // one generator run, then status, counters and error counts
    task automatic run(input logic [5:0] ctl, input logic [15:0] len, input int n, input logic [1:0] kind);
        int          t0;
        logic [31:0] c0;
        exp_len = ctl[CTRL_RANDOM] ? 16'h0 : len;
        fix_pl = ctl[CTRL_FIXPL];
        exp_seq = 32'h100 + 32'(nfr);
        bad_kind <= kind;
        bad_frame <= 8'(nfr + n - 1);
        wr(REG_LEN, {16'h0, len});
        wr(REG_BURST, 32'(n));
        wr(REG_SEQ0, exp_seq);
        wr(REG_CTRL, 32'h20);
        bus(1'b0, REG_TX_CNT, '0, 1'b0);
        c0 = rd;
        t0 = nfr;
        wr(REG_CTRL, 32'(ctl) | 32'h1);
        for (int i = 0; i < 40000 && nfr - t0 < n; i++) @(posedge clk);
        if (!ctl[CTRL_BURST]) begin
            wr(REG_CTRL, 32'(ctl) | 32'h2);
            do bus(1'b0, REG_STATUS, '0, 1'b0); while (rd[0] !== 1'b0);
            repeat (100) @(posedge clk);
            n = nfr - t0;
        end
        chk("frames sent", 32'(n), 32'(nfr - t0));
        rdc(REG_STATUS, {30'h0, ctl[CTRL_BURST], 1'b0});
        rdc(REG_TX_CNT, c0 + 32'(n));
        rdc(REG_RX_CNT, 32'(n));
        rdc(REG_ERR_INT, {31'h0, kind == 2'h2});
        rdc(REG_ERR_SEQ, {31'h0, kind == 2'h1});
        rdc(REG_ERR_LEN, {31'h0, kind == 2'h3});
        chk("rx ready", 32'h1, {31'h0, rx_ready});
    endtask

    initial begin
        void'($urandom(83));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc(REG_LEN, {16'h0, LEN_RESET});
        rdc(REG_BURST, BURST_RESET);
        rdc(REG_PAYLOAD, PAYLOAD_RESET);
        rdc(4'hf, 32'h0);
        wr(REG_LEN, 32'd20);
        rdc(REG_LEN, {16'h0, LEN_MIN});
        wr(REG_LEN, 32'd40000);
        rdc(REG_LEN, {16'h0, LEN_MAX});
        wr(REG_PAYLOAD, PAY);
        rdc(REG_PAYLOAD, PAY);
        run(6'h0c, 16'd70, 3, 2'h0);
        run(6'h04, LEN_MIN, 2, 2'h1);
        run(6'h14, 16'd100, 3, 2'h2);
        run(6'h04, LEN_MAX, 1, 2'h3);
        run(6'h08, 16'd64, 20, 2'h0);
        stop_test();
    end
endmodule

//--- pkt_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; read data come from a register
module pkt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic             ov_q, ov_d;
    logic             push, pop, load;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign load      = (cnt_q != '0) && (!ov_q || out_ready);
    assign pop       = load;
    assign out_valid = ov_q;
    assign out_data  = out_q;

    always_comb begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = (AW+1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        out_d = load ? mem[rd_q] : out_q;
        ov_d  = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            out_q <= '0;
            ov_q  <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ov_q  <= ov_d;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rstn)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

//--- pkt_mon.sv
// receive monitor: parses frames, checks integrity, sequence and length
// assumes the mac has stripped crc and preamble; frame starts with a
// 32-bit sequence in the low word and a 16-bit length in the next bits
module pkt_mon
    import pkt_client_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  pkt_client_pkg::beat_s rx_beat,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic        clr,
    input  wire logic [31:0] seq_first,
    output logic [31:0]      rx_cnt,
    output logic [31:0]      err_int,
    output logic [31:0]      err_seq,
    output logic [31:0]      err_len
);
    logic [31:0]      exp_q, exp_d, rc_q, rc_d, ei_q, ei_d, es_q, es_d, el_q, el_d;
    logic [LEN_W-1:0] hdr_q, hdr_d, acc_q, acc_d;
    logic             in_q, in_d;
    logic [LEN_W-1:0] total;
    logic             take;

    assign rx_ready = 1'b1;
    assign take     = rx_valid;
    assign total    = LEN_W'(acc_q + LEN_W'(6'd32 - {1'b0, rx_beat.empty}));

    always_comb begin
        exp_d = exp_q;
        rc_d  = rc_q;
        ei_d  = ei_q;
        es_d  = es_q;
        el_d  = el_q;
        hdr_d = hdr_q;
        acc_d = acc_q;
        in_d  = in_q;
        if (clr) begin
            exp_d = seq_first;
            rc_d  = '0;
            ei_d  = '0;
            es_d  = '0;
            el_d  = '0;
            in_d  = 1'b0;
        end else if (take) begin
            // integrity: framing order and mac error flag
            if ((rx_beat.sop && in_q) || (!rx_beat.sop && !in_q) || (rx_beat.eop && rx_beat.error)) begin
                ei_d = ei_q + 32'd1;
            end
            if (rx_beat.sop) begin
                // sequence check against expected
                if (rx_beat.data[31:0] != exp_q) begin
                    es_d = es_q + 32'd1;
                end
                exp_d = rx_beat.data[31:0] + 32'd1;
                hdr_d = rx_beat.data[47:32];
                acc_d = '0;
                in_d  = 1'b1;
            end
            if (rx_beat.eop) begin
                rc_d = rc_q + 32'd1;
                in_d = 1'b0;
                // length check against header
                if ((rx_beat.sop ? LEN_W'(6'd32 - {1'b0, rx_beat.empty}) : total) != (rx_beat.sop ? rx_beat.data[47:32] : hdr_q)) begin
                    el_d = el_q + 32'd1;
                end
            end else begin
                acc_d = rx_beat.sop ? LEN_W'(32) : LEN_W'(acc_q + LEN_W'(32));
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            exp_q <= '0;
            rc_q  <= '0;
            ei_q  <= '0;
            es_q  <= '0;
            el_q  <= '0;
            hdr_q <= '0;
            acc_q <= '0;
            in_q  <= 1'b0;
        end else begin
            exp_q <= exp_d;
            rc_q  <= rc_d;
            ei_q  <= ei_d;
            es_q  <= es_d;
            el_q  <= el_d;
            hdr_q <= hdr_d;
            acc_q <= acc_d;
            in_q  <= in_d;
        end
    end

    assign rx_cnt  = rc_q;
    assign err_int = ei_q;
    assign err_seq = es_q;
    assign err_len = el_q;

    a_mon_count_eop: assert property (@(posedge clk) disable iff (!rstn)
        (rx_valid && rx_beat.eop && !clr) |=> rc_q == $past(rc_q) + 32'd1) else $error("frame not counted");
    a_mon_seq_err: assert property (@(posedge clk) disable iff (!rstn)
        (rx_valid && rx_beat.sop && !clr && rx_beat.data[31:0] != exp_q) |=> es_q != $past(es_q))
        else $error("sequence mismatch missed");
    a_mon_int_err: assert property (@(posedge clk) disable iff (!rstn)
        (rx_valid && !rx_beat.sop && !in_q && !clr) |=> ei_q == $past(ei_q) + 32'd1)
        else $error("orphan beat not flagged");
    c_mon_frame: cover property (@(posedge clk) disable iff (!rstn) rx_valid && rx_beat.eop && !rx_beat.sop);
endmodule
